/* File: core/light_prox_irq.sv */
// Purpose: Threshold, persistence and interrupt logic for the light and proximity channels
// Assumes: Host register access arrives as strobes on clk; measurements arrive on link_clk
// Notes:   Interrupt pin is open drain; its enable is low while the pin is pulled low
//
// Function
// - Each range option doubles light full scale
// - Light interrupt after 1, 2, 4, 8 outside
// - Light event above high or below low
// - Proximity interrupt after 1 to 4 above
// - Forced mode: one proximity result per trigger
// - Configuration registers read back their contents
// - Light result as low and high byte
// - Proximity result is raw minus crosstalk offset
// - Shared pin driven low only when enabled, except in logic mode
// - Registers stay accessible while pin asserted
// - Any flag rising pulls the pin low, except in logic mode
// - Flag read clears flags, pin released
// - Logic mode: pin follows approach and recede
// - Logic mode pin carries no light interrupts
// - No proximity event between the thresholds
// - Trigger select chooses proximity crossings
// - Flag byte holds five separate event bits

`timescale 1ns/1ps

module light_prox_irq
    import light_prox_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic                        link_clk,
    input  wire logic                        meas_valid,
    input  wire light_prox_pkg::meas_t       meas,
    output logic                             meas_busy_r,
    input  wire logic                        cfg_wr,
    input  wire light_prox_pkg::cfg_t        cfg_in,
    output light_prox_pkg::cfg_t             cfg_r,
    input  wire logic                        prox_single_shot_trigger,
    input  wire logic                        flag_rd,
    output logic [7:0]                       flag_rd_data_r,
    output logic [7:0]                       light_result_low_byte,
    output logic [7:0]                       light_result_high_byte,
    output logic [17:0]                      light_scaled_r,
    output logic [15:0]                      prox_result,
    output logic                             prox_run_r,
    output logic                             prox_shot_toggle_r,
    output logic                             prox_close_r,
    output logic                             int_pin_out_r,
    output logic                             int_pin_oe_n_r
);

    import light_prox_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic              rx_valid;
    meas_t             rx;
    logic [7:0]        flags_r;
    logic [7:0]        flags_set;
    logic [7:0]        flags_clr;
    logic [3:0]        light_cnt_r;
    logic [2:0]        prox_cnt_r;
    logic              shot_pending_r;
    logic              light_new;
    logic              light_above;
    logic              light_below;
    logic              light_outside;
    logic              light_hit;
    logic              prox_accept;
    logic [15:0]       prox_val;
    logic              prox_above;
    logic              prox_below;
    logic              close_hit;
    logic              away_hit;
    logic              irq_enabled;
    logic              pin_drive;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] light_target(input logic [1:0] code);
        light_target = 4'h1 << code;
    endfunction

    function automatic logic [2:0] prox_target(input logic [1:0] code);
        prox_target = {1'b0, code} + 3'h1;
    endfunction

    // Clamp at zero: an offset larger than the raw count must not wrap
    function automatic logic [15:0] sub_clamp(input logic [15:0] a, input logic [15:0] b);
        sub_clamp = (a > b) ? (a - b) : 16'h0000;
    endfunction

    // ------------------------------------------------------------
    // Measurement crossing from the link domain
    // ------------------------------------------------------------
    logic [MEAS_W-1:0] rx_bits;

    word_handshake_sync #(
        .W          (MEAS_W)
    ) u_meas_sync (
        .src_clk    (link_clk),
        .src_resetn (resetn),
        .src_valid  (meas_valid),
        .src_data   (meas),
        .src_busy_r (meas_busy_r),
        .dst_clk    (clk),
        .dst_resetn (resetn),
        .dst_valid_r(rx_valid),
        .dst_data_r (rx_bits)
    );

    assign rx = meas_t'(rx_bits);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Writes are taken whatever the pin shows
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= CFG_RESET;
        end else if (cfg_wr) begin
            cfg_r <= cfg_in; // Output port mirrors the stored value
        end
    end

    // ------------------------------------------------------------
    // Light channel
    // ------------------------------------------------------------
    assign light_new     = rx_valid && !rx.is_prox;
    assign light_above   = rx.value > cfg_r.light_high_threshold;
    assign light_below   = rx.value < cfg_r.light_low_threshold;
    assign light_outside = light_above || light_below;
    assign light_hit     = light_new && light_outside &&
                           ((light_cnt_r + 4'h1) >= light_target(cfg_r.light_persistence_count));

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            light_cnt_r <= LIGHT_CNT_RESET;
        end else if (light_new) begin
            if (!light_outside) begin
                light_cnt_r <= LIGHT_CNT_RESET;
            end else if (light_cnt_r < light_target(cfg_r.light_persistence_count)) begin
                light_cnt_r <= light_cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            light_result_low_byte  <= 8'h00;
            light_result_high_byte <= 8'h00;
            light_scaled_r         <= 18'h00000;
        end else if (light_new) begin
            light_result_low_byte  <= rx.value[7:0];
            light_result_high_byte <= rx.value[15:8];
            // Each option doubles the count weight, so full scale doubles per step
            light_scaled_r <= ({2'b00, rx.value} << cfg_r.light_high_dynamic_option)
                              << cfg_r.light_range_doubling_option;
        end
    end

    // ------------------------------------------------------------
    // Proximity channel
    // ------------------------------------------------------------
    // In forced mode only a result paid for by a trigger is taken
    assign prox_accept = rx_valid && rx.is_prox && (!cfg_r.prox_forced_mode || shot_pending_r);
    assign prox_val    = sub_clamp(rx.value, cfg_r.prox_crosstalk_offset);
    assign prox_above  = prox_val > cfg_r.prox_high_threshold;
    assign prox_below  = prox_val < cfg_r.prox_low_threshold;
    // Mechanism 1 reports only state changes; 0 reports every crossing
    assign close_hit   = prox_accept && prox_above &&
                         ((prox_cnt_r + 3'h1) >= prox_target(cfg_r.prox_persistence_count)) &&
                         !(cfg_r.prox_detect_mechanism_select && prox_close_r);
    assign away_hit    = prox_accept && prox_below &&
                         (!cfg_r.prox_detect_mechanism_select || prox_close_r);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prox_cnt_r <= PROX_CNT_RESET;
        end else if (prox_accept) begin
            if (!prox_above) begin
                prox_cnt_r <= PROX_CNT_RESET;
            end else if (prox_cnt_r < prox_target(cfg_r.prox_persistence_count)) begin
                prox_cnt_r <= prox_cnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prox_result  <= 16'h0000;
            prox_close_r <= 1'b0;
        end else if (prox_accept) begin
            prox_result <= prox_val;
            if (prox_above && (prox_cnt_r + 3'h1) >= prox_target(cfg_r.prox_persistence_count)) begin
                prox_close_r <= 1'b1;
            end else if (prox_below) begin
                prox_close_r <= 1'b0; // Between thresholds the state holds
            end
        end
    end

    // ------------------------------------------------------------
    // Forced single-shot control
    // ------------------------------------------------------------
    // The shot request crosses as a toggle so the front end sees every one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prox_run_r         <= 1'b0;
            prox_shot_toggle_r <= 1'b0;
            shot_pending_r     <= 1'b0;
        end else begin
            prox_run_r <= !cfg_r.prox_forced_mode;
            if (cfg_r.prox_forced_mode && prox_single_shot_trigger) begin
                prox_shot_toggle_r <= ~prox_shot_toggle_r;
                shot_pending_r     <= 1'b1;
            end else if (prox_accept || !cfg_r.prox_forced_mode) begin
                shot_pending_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    always_comb begin
        flags_set = FLAGS_RESET;
        flags_set[FLAG_OVER_BIT]  = light_hit && light_above && cfg_r.light_irq_enable;
        flags_set[FLAG_UNDER_BIT] = light_hit && light_below && cfg_r.light_irq_enable;
        flags_set[FLAG_CLOSE_BIT] = close_hit && cfg_r.prox_irq_trigger_select[0];
        flags_set[FLAG_AWAY_BIT]  = away_hit && cfg_r.prox_irq_trigger_select[1];
        flags_set[FLAG_SUN_BIT]   = prox_accept && rx.sunlight &&
                                    (cfg_r.prox_irq_trigger_select != PROX_SEL_OFF);
    end

    assign flags_clr = flag_rd ? flags_r : FLAGS_RESET;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_r        <= FLAGS_RESET;
            flag_rd_data_r <= FLAGS_RESET;
        end else begin
            // A new event in the read cycle survives the clear
            flags_r <= (flags_r & ~flags_clr) | flags_set;
            if (flag_rd) begin
                flag_rd_data_r <= flags_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Shared pin
    // ------------------------------------------------------------
    assign irq_enabled = cfg_r.light_irq_enable || (cfg_r.prox_irq_trigger_select != PROX_SEL_OFF);
    // Logic mode hides all flags from the pin
    assign pin_drive   = cfg_r.prox_output_mode_select ? prox_close_r
                                                       : ((flags_r != FLAGS_RESET) && irq_enabled);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_pin_out_r  <= 1'b0;
            int_pin_oe_n_r <= 1'b1;
        end else begin
            int_pin_out_r  <= 1'b0;
            int_pin_oe_n_r <= !pin_drive;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_light_over;
        light_hit && light_above && cfg_r.light_irq_enable |=> flags_r[FLAG_OVER_BIT];
    endproperty
    a_light_over: assert property (p_light_over) else $error("light over flag not set");

    property p_light_restart;
        light_new && !light_outside |=> light_cnt_r == 4'h0;
    endproperty
    a_light_restart: assert property (p_light_restart) else $error("light count not restarted");

    property p_light_pers;
        light_new && light_outside && ((light_cnt_r + 4'h1) < light_target(cfg_r.light_persistence_count))
            && !flags_r[FLAG_OVER_BIT] && !flags_r[FLAG_UNDER_BIT]
            |=> !flags_r[FLAG_OVER_BIT] && !flags_r[FLAG_UNDER_BIT];
    endproperty
    a_light_pers: assert property (p_light_pers) else $error("light flag before persistence");

    property p_prox_pers;
        prox_accept && prox_above && ((prox_cnt_r + 3'h1) < prox_target(cfg_r.prox_persistence_count))
            && !flags_r[FLAG_CLOSE_BIT] |=> !flags_r[FLAG_CLOSE_BIT];
    endproperty
    a_prox_pers: assert property (p_prox_pers) else $error("approach flag before persistence");

    property p_pin_low;
        (flags_r != FLAGS_RESET) && irq_enabled && !cfg_r.prox_output_mode_select |=> !int_pin_oe_n_r;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin not pulled low on flag");

    property p_read_clear;
        flag_rd && (flags_set == FLAGS_RESET) |=> (flags_r == FLAGS_RESET) ##1 int_pin_oe_n_r
            || cfg_r.prox_output_mode_select || flags_r != FLAGS_RESET;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag read did not release pin");

    property p_forced_hold;
        cfg_r.prox_forced_mode && !shot_pending_r && rx_valid && rx.is_prox |=> $stable(prox_result);
    endproperty
    a_forced_hold: assert property (p_forced_hold) else $error("unrequested proximity result");

    property p_hyst;
        prox_accept && !prox_above && !prox_below && !flag_rd |=> $stable(flags_r[1:0]) && $stable(prox_close_r);
    endproperty
    a_hyst: assert property (p_hyst) else $error("event between thresholds");

    property p_logic_mode;
        cfg_r.prox_output_mode_select |=> int_pin_oe_n_r == !$past(prox_close_r);
    endproperty
    a_logic_mode: assert property (p_logic_mode) else $error("logic mode pin mismatch");

    property p_sun_flag;
        prox_accept && rx.sunlight && (cfg_r.prox_irq_trigger_select != PROX_SEL_OFF) |=> flags_r[FLAG_SUN_BIT];
    endproperty
    a_sun_flag: assert property (p_sun_flag) else $error("sunlight flag not set");

    property p_light_bytes;
        light_new |=> {light_result_high_byte, light_result_low_byte} == $past(rx.value);
    endproperty
    a_light_bytes: assert property (p_light_bytes) else $error("light bytes not split");

    property p_cfg_wr;
        cfg_wr |=> cfg_r == $past(cfg_in);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("configuration not stored");

endmodule

/* File: inc/light_prox_pkg.sv */
// Purpose: Shared constants and carriers for the light and proximity interrupt logic
// Assumes: One host-side clock domain and one measurement link clock domain
// Notes:   Flag byte layout and reset values live here only

package light_prox_pkg;

    // ------------------------------------------------------------
    // Flag byte layout
    // ------------------------------------------------------------
    localparam int         FLAG_W            = 8;
    localparam int         FLAG_AWAY_BIT     = 0;
    localparam int         FLAG_CLOSE_BIT    = 1;
    localparam int         FLAG_SUN_BIT      = 2;
    localparam int         FLAG_OVER_BIT     = 4;
    localparam int         FLAG_UNDER_BIT    = 5;
    localparam logic [7:0] FLAGS_RESET       = 8'h00;

    // ------------------------------------------------------------
    // Data widths and proximity trigger select codes
    // ------------------------------------------------------------
    localparam int         DATA_W            = 16;
    localparam int         SCALED_W          = 18;
    localparam logic [1:0] PROX_SEL_OFF      = 2'h0;
    localparam logic [1:0] PROX_SEL_CLOSE    = 2'h1;
    localparam logic [1:0] PROX_SEL_AWAY     = 2'h2;
    localparam logic [1:0] PROX_SEL_BOTH     = 2'h3;
    localparam logic [3:0] LIGHT_CNT_RESET   = 4'h0;
    localparam logic [2:0] PROX_CNT_RESET    = 3'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              light_high_dynamic_option;
        logic              light_range_doubling_option;
        logic [1:0]        light_persistence_count;
        logic              light_irq_enable;
        logic [15:0]       light_high_threshold;
        logic [15:0]       light_low_threshold;
        logic [1:0]        prox_persistence_count;
        logic [15:0]       prox_high_threshold;
        logic [15:0]       prox_low_threshold;
        logic              prox_forced_mode;
        logic [1:0]        prox_irq_trigger_select;
        logic              prox_detect_mechanism_select;
        logic              prox_output_mode_select;
        logic [15:0]       prox_crosstalk_offset;
    } cfg_t;

    typedef struct packed {
        logic              is_prox;
        logic              sunlight;
        logic [15:0]       value;
    } meas_t;

    localparam cfg_t       CFG_RESET         = '0;
    localparam int         MEAS_W            = $bits(meas_t);

endpackage

/* File: core/word_handshake_sync.sv */
// Purpose: Carries one word from the link clock domain into the host clock domain
// Assumes: Source holds no new word while busy is high
// Notes:   Toggle request and toggle acknowledge, two flip-flops each way

`timescale 1ns/1ps

module word_handshake_sync #(
    parameter int W = 18
) (
    input  wire logic         src_clk,
    input  wire logic         src_resetn,
    input  wire logic         src_valid,
    input  wire logic [W-1:0] src_data,
    output logic              src_busy_r,
    input  wire logic         dst_clk,
    input  wire logic         dst_resetn,
    output logic              dst_valid_r,
    output logic [W-1:0]      dst_data_r
);

    logic [W-1:0] hold_r;
    logic         req_r;
    logic         ack_meta_r;
    logic         ack_sync_r;
    logic         req_meta_r;
    logic         req_sync_r;
    logic         req_seen_r;

    // ------------------------------------------------------------
    // Source side
    // ------------------------------------------------------------
    // Data stays frozen while the request is outstanding, so the far side
    // may sample it without a synchroniser of its own.
    always_ff @(posedge src_clk or negedge src_resetn) begin
        if (!src_resetn) begin
            hold_r <= '0;
            req_r  <= 1'b0;
        end else if (src_valid && !src_busy_r) begin
            hold_r <= src_data;
            req_r  <= ~req_r;
        end
    end

    always_ff @(posedge src_clk or negedge src_resetn) begin
        if (!src_resetn) begin
            ack_meta_r <= 1'b0;
            ack_sync_r <= 1'b0;
            src_busy_r <= 1'b0;
        end else begin
            ack_meta_r <= req_seen_r;
            ack_sync_r <= ack_meta_r;
            src_busy_r <= (src_valid && !src_busy_r) ? 1'b1 : (req_r != ack_sync_r);
        end
    end

    // ------------------------------------------------------------
    // Destination side
    // ------------------------------------------------------------
    always_ff @(posedge dst_clk or negedge dst_resetn) begin
        if (!dst_resetn) begin
            req_meta_r  <= 1'b0;
            req_sync_r  <= 1'b0;
            req_seen_r  <= 1'b0;
            dst_valid_r <= 1'b0;
            dst_data_r  <= '0;
        end else begin
            req_meta_r  <= req_r;
            req_sync_r  <= req_meta_r;
            req_seen_r  <= req_sync_r;
            dst_valid_r <= req_sync_r != req_seen_r;
            if (req_sync_r != req_seen_r) begin
                dst_data_r <= hold_r;
            end
        end
    end

endmodule

/* File: testbench/meas_source.sv */
// Purpose: Measurement front end model on the link clock
// Assumes: One word in flight at a time
// Notes:   Idle data shows the inverse of the last word, so a stale sample is never mistaken
`timescale 1ns/1ps
module meas_source (
    output logic                  link_clk,
    output logic                  meas_valid,
    output light_prox_pkg::meas_t meas,
    input  wire logic             meas_busy_r
);
    import light_prox_pkg::*;
    initial begin
        meas_valid = 1'b0;
        meas       = '0;
        link_clk   = 1'b0;
        #37;
        forever #62.5 link_clk = ~link_clk;
    end
    // Bounded wait for busy to drop, so a stuck flag cannot hang the run
    task automatic send(input logic p, input logic [15:0] v, output bit ok, input logic s = 1'b0);
        int n;
        n = 0;
        @(posedge link_clk);
        meas_valid <= 1'b1;
        meas       <= {p, s, v};
        @(posedge link_clk);
        meas_valid <= 1'b0;
        meas       <= ~{p, s, v};
        do begin
            @(posedge link_clk);
            n++;
        end while (meas_busy_r !== 1'b0 && n < 60);
        ok = (n < 60);
    endtask
endmodule

/* File: testbench/light_prox_interrupt_logic_bench.sv */
// Purpose: Self-checking bench for the light and proximity interrupt logic
// Assumes: Reset held long enough for both clocks
// Notes:   Pin level is checked through the open-drain enable
`timescale 1ns/1ps
module light_proximity_interrupt_logic_bench;
    import light_prox_pkg::*;
    logic        clk, resetn, cfg_wr, trig, flag_rd, link_clk, meas_valid, busy, shot, run, oe_n, pout, close;
    cfg_t        cfg_in, cfg_r, c;
    meas_t       meas;
    logic [7:0]  fdata, lo_b, hi_b;
    logic [17:0] scaled;
    logic [15:0] pres;
    int          errors, num_checks;

    light_prox_irq i_dut (.clk(clk), .resetn(resetn), .link_clk(link_clk), .meas_valid(meas_valid),
        .meas(meas), .meas_busy_r(busy), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .cfg_r(cfg_r),
        .prox_single_shot_trigger(trig), .flag_rd(flag_rd), .flag_rd_data_r(fdata),
        .light_result_low_byte(lo_b), .light_result_high_byte(hi_b), .light_scaled_r(scaled),
        .prox_result(pres), .prox_run_r(run), .prox_shot_toggle_r(shot), .prox_close_r(close),
        .int_pin_out_r(pout), .int_pin_oe_n_r(oe_n));
    meas_source i_src (.link_clk(link_clk), .meas_valid(meas_valid), .meas(meas), .meas_busy_r(busy));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        errors++;
        results();
    end
    task automatic chk(input string name, input logic [95:0] exp, input logic [95:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic results();
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wcfg(input cfg_t v);
        @(posedge clk) cfg_wr <= 1'b1;
        cfg_in <= v;
        @(posedge clk) cfg_wr <= 1'b0;
        @(posedge clk) #1;
        chk("cfg", v, cfg_r);
    endtask
    task automatic rflag(input logic [7:0] ef, input logic [7:0] mask);
        @(posedge clk) flag_rd <= 1'b1;
        @(posedge clk) flag_rd <= 1'b0;
        @(posedge clk) #1;
        chk("flags", ef, fdata & mask);
        @(posedge clk) #1;
        chk("pin_release", 1'b1, oe_n);
    endtask
    // Sends the word the given number of times, letting each result settle in the host domain
    task automatic meas_in(input logic p, input logic [15:0] v, input int times, input logic s = 1'b0);
        bit ok;
        repeat (times) begin
            i_src.send(p, v, ok, s);
            if (!ok) begin
                errors++;
                results();
            end
            repeat (3) @(posedge clk);
            #1;
        end
    endtask

    initial begin
        resetn = 1'b0; cfg_wr = 1'b0; trig = 1'b0; flag_rd = 1'b0; cfg_in = CFG_RESET;
        errors = 0; num_checks = 0;
        repeat (4) @(posedge clk);
        #1 chk("pin_rst", 1'b1, oe_n);
        chk("cfg_rst", CFG_RESET, cfg_r);
        @(posedge clk) resetn <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("run_cont", 1'b1, run);
        c = CFG_RESET;
        c.light_irq_enable = 1'b1; c.light_persistence_count = 2'h2;
        c.light_high_threshold = 16'h1000; c.light_low_threshold = 16'h0100;
        wcfg(c);
        for (int i = 0; i < 8; i++) begin
            meas_in(1'b0, (i == 3) ? 16'h0800 : 16'h1234, 1);
            chk("light_pin", (i == 7) ? 1'b0 : 1'b1, oe_n);
        end
        for (int k = 0; k < 4; k++) begin
            c.light_high_dynamic_option = k[0]; c.light_range_doubling_option = k[1];
            wcfg(c);
            meas_in(1'b0, 16'h1234, 1);
            chk("scaled", 18'h01234 << (int'(k[0]) + int'(k[1])), scaled);
        end
        chk("low_byte", 8'h34, lo_b);
        chk("high_byte", 8'h12, hi_b);
        chk("pin_value", 1'b0, pout);
        rflag(8'h10, 8'hFF);
        c.light_persistence_count = 2'h0;
        wcfg(c);
        meas_in(1'b0, 16'h0050, 1);
        chk("under_pin", 1'b0, oe_n);
        c.light_irq_enable = 1'b0;
        wcfg(c);
        repeat (2) @(posedge clk);
        #1 chk("disabled_pin", 1'b1, oe_n);
        rflag(8'h20, 8'hFF);
        c = CFG_RESET;
        c.prox_persistence_count = 2'h1; c.prox_high_threshold = 16'h0100; c.prox_low_threshold = 16'h0080;
        c.prox_irq_trigger_select = PROX_SEL_BOTH; c.prox_detect_mechanism_select = 1'b1;
        c.prox_crosstalk_offset = 16'h0010;
        wcfg(c);
        meas_in(1'b1, 16'h0050, 1, 1'b1);
        chk("prox_result", 16'h0040, pres);
        rflag(8'h04, 8'hFF);
        meas_in(1'b1, 16'h0200, 1);
        chk("prox_pers1", 1'b1, oe_n);
        meas_in(1'b1, 16'h0200, 1);
        chk("prox_pers2", 1'b0, oe_n);
        rflag(8'h02, 8'hFF);
        meas_in(1'b1, 16'h00C0, 2);
        chk("hyst_pin", 1'b1, oe_n);
        meas_in(1'b1, 16'h0020, 2);
        chk("away_pin", 1'b0, oe_n);
        rflag(8'h01, 8'hFF);
        c.prox_irq_trigger_select = PROX_SEL_CLOSE;
        wcfg(c);
        meas_in(1'b1, 16'h0200, 2);
        rflag(8'h02, 8'hFF);
        meas_in(1'b1, 16'h0020, 2);
        chk("close_only", 1'b1, oe_n);
        c.prox_output_mode_select = 1'b1; c.light_irq_enable = 1'b1;
        wcfg(c);
        meas_in(1'b0, 16'h0050, 1);
        chk("logic_light", 1'b1, oe_n);
        meas_in(1'b1, 16'h0200, 2);
        chk("logic_near", 1'b0, oe_n);
        chk("close_state", 1'b1, close);
        meas_in(1'b1, 16'h0020, 2);
        chk("logic_far", 1'b1, oe_n);
        c.prox_output_mode_select = 1'b0;
        wcfg(c);
        @(posedge clk) #1 chk("normal_pin", 1'b0, oe_n);
        rflag(8'h12, 8'hFF);
        c = CFG_RESET;
        c.prox_forced_mode = 1'b1; c.prox_crosstalk_offset = 16'h0010;
        wcfg(c);
        @(posedge clk) #1 chk("run", 1'b0, run);
        meas_in(1'b1, 16'h0090, 1);
        chk("no_shot", 16'h0010, pres);
        c.prox_crosstalk_offset = {15'h0, shot};
        @(posedge clk) trig <= 1'b1;
        @(posedge clk) trig <= 1'b0;
        @(posedge clk) #1 chk("toggle", !c.prox_crosstalk_offset[0], shot);
        meas_in(1'b1, 16'h0090, 1);
        chk("one_shot", 16'h0080, pres);
        meas_in(1'b1, 16'h00A0, 1);
        chk("shot_used", 16'h0080, pres);
        results();
    end
endmodule
